/* dv/ddc_dual_dac_ctrl_asserts.sv */
`timescale 1ns/1ps
module ddc_chk
#(
    parameter CODE_W = 12
)
(
    input wire logic              core_clk_in,
    input wire logic              resetn_in,
    input wire logic [7:0]        sfr_addr_in,
    input wire logic              sfr_wr_in,
    input wire logic [7:0]        sfr_wdata_in,
    input wire logic              sfr_rd_in,
    input wire logic [7:0]        sfr_rdata_out,
    input wire logic              sfr_hit_out,
    input wire logic [CODE_W-1:0] ch0_code_out,
    input wire logic [CODE_W-1:0] ch1_code_out,
    input wire logic              ch0_span_supply_out,
    input wire logic              ch1_span_supply_out,
    input wire logic              ch0_drive_en_out,
    input wire logic              ch1_drive_en_out,
    input wire logic              mode8_out
);
    wire cw = sfr_wr_in && sfr_addr_in == 8'hFD;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    AST_MODE: assert property (cw |=>
        mode8_out == $past(sfr_wdata_in[7]))
        else $error("mode bit not taken");
    AST_SPAN: assert property (cw |=>
        {ch1_span_supply_out, ch0_span_supply_out} == $past(sfr_wdata_in[6:5]))
        else $error("span bits not taken");
    AST_ZERO: assert property (cw |=>
        ($past(sfr_wdata_in[3]) || ch0_code_out == 12'h000) &&
        ($past(sfr_wdata_in[4]) || ch1_code_out == 12'h000))
        else $error("zero force not applied");
    AST_PWR: assert property (cw |=>
        {ch1_drive_en_out, ch0_drive_en_out} == $past(sfr_wdata_in[1:0]))
        else $error("power bits not taken");
    AST_HOLD: assert property (!sfr_wr_in |=>
        $stable(ch0_code_out) && $stable(ch1_code_out))
        else $error("code moved without write");
    AST_HIT: assert property (sfr_hit_out ==
        (sfr_addr_in >= 8'hF9 && sfr_addr_in <= 8'hFD))
        else $error("address decode wrong");
    AST_RST: assert property ($rose(resetn_in) |->
        !ch0_drive_en_out && !ch1_drive_en_out)
        else $error("channel enabled after reset");
    AST_UNMAP: assert property (sfr_rd_in && !sfr_hit_out |=>
        sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind ddc_dual_dac_ctrl ddc_chk #(.CODE_W(CODE_W)) ddc_chk_i (.core_clk_in,
    .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rd_in,
    .sfr_rdata_out, .sfr_hit_out, .ch0_code_out, .ch1_code_out,
    .ch0_span_supply_out, .ch1_span_supply_out, .ch0_drive_en_out,
    .ch1_drive_en_out, .mode8_out);

/* dv/ddc_dual_dac_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module ddc_dual_dac_ctrl_tb;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0;
    logic [7:0]  addr = 0, wdata = 0;
    wire  [7:0]  rdata;
    wire  [11:0] c0, c1;
    wire         s0, s1, d0, d1, m8;
    int          n_mismatch = 0, n_compared = 0;
    ddc_dual_dac_ctrl ddc_dual_dac_ctrl_i (.core_clk_in(clk),
        .resetn_in(rstn), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_wdata_in(wdata), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
        .sfr_hit_out(), .ch0_code_out(c0), .ch1_code_out(c1),
        .ch0_span_supply_out(s0), .ch1_span_supply_out(s1),
        .ch0_drive_en_out(d0), .ch1_drive_en_out(d1), .mode8_out(m8));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask
    task automatic t_reset;
        for (int a = 'hF9; a <= 'hFC; a++) rd_chk(a[7:0], 8'h00);
        rd_chk(8'hFD, 8'h04);
        `CHK({d1, d0, c1, c0}, 26'h0)
    endtask
    task automatic t_sync_on;
        wr_reg(8'hFD, 8'h1F);
        wr_reg(8'hFA, 8'h05);
        wr_reg(8'hF9, 8'h23);
        `CHK(c0, 12'h523)
        wr_reg(8'hFC, 8'h0A);
        wr_reg(8'hFB, 8'hBC);
        `CHK(c1, 12'hABC)
        rd_chk(8'hFA, 8'h05);
    endtask
    task automatic t_sync_off;
        wr_reg(8'hFD, 8'h1B);
        wr_reg(8'hFA, 8'h01);
        wr_reg(8'hF9, 8'h11);
        wr_reg(8'hFB, 8'h22);
        `CHK({c1, c0}, 24'hABC523)
        wr_reg(8'hFD, 8'h1F);
        `CHK({c1, c0}, 24'hA22111)
    endtask
    task automatic t_mode;
        wr_reg(8'hFD, 8'hFF);
        wr_reg(8'hF9, 8'h7E);
        `CHK(c0, 12'h07E)
        `CHK({m8, s1, s0, d1, d0}, 5'h1F)
        wr_reg(8'hFD, 8'h67);
        `CHK({m8, c1, c0}, 25'h0)
        wr_reg(8'hFD, 8'h1C);
        `CHK({s1, s0, d1, d0}, 4'h0)
        `CHK({c1, c0}, 24'hA2207E)
        wr_reg(8'hF8, 8'h55);
        rd_chk(8'hF8, 8'h00);
        rd_chk(8'hFD, 8'h1C);
    endtask
    task automatic finish_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_sync_on;
        t_sync_off;
        t_mode;
        finish_test;
    end
endmodule

/* include/ddc_consts.vh */
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH

`define DDC_ADDR_CH0_LOW   8'hF9
`define DDC_ADDR_CH0_HIGH  8'hFA
`define DDC_ADDR_CH1_LOW   8'hFB
`define DDC_ADDR_CH1_HIGH  8'hFC
`define DDC_ADDR_CONTROL   8'hFD

`define DDC_RST_DATA       8'h00
`define DDC_RST_CONTROL    8'h04

`define DDC_BIT_MODE8      7
`define DDC_BIT_SPAN1      6
`define DDC_BIT_SPAN0      5
`define DDC_BIT_NZERO1     4
`define DDC_BIT_NZERO0     3
`define DDC_BIT_SYNC       2
`define DDC_BIT_PWR1       1
`define DDC_BIT_PWR0       0

`define DDC_HIGH_NIBBLE_MSB 3
`define DDC_CODE_ZERO      12'h000
`define DDC_NIBBLE_ZERO    4'h0

`endif

/* rtl/ddc_channel.v */
`timescale 1ns/1ps
`include "ddc_consts.vh"

module ddc_channel
#(
    parameter CODE_W = 12
)
(
    input  wire              core_clk_in,
    input  wire              resetn_in,
    input  wire              mode8_in,
    input  wire              sync_in,
    input  wire              sync_rise_in,
    input  wire              low_wr_in,
    input  wire [7:0]        low_val_in,
    input  wire [7:0]        high_val_in,
    input  wire              nzero_in,
    input  wire              power_in,
    output wire [CODE_W-1:0] code_out,
    output wire              drive_en_out
);

    reg  [CODE_W-1:0] code_reg;
    reg  [CODE_W-1:0] code_next;
    wire [CODE_W-1:0] staged;

    // 8-bit mode uses the low byte only, the high byte is ignored
    assign staged = mode8_in ?
        {`DDC_NIBBLE_ZERO, low_val_in} :
        {high_val_in[`DDC_HIGH_NIBBLE_MSB:0], low_val_in};

    always @*
    begin
        code_next = code_reg;
        if (sync_in && low_wr_in)
            code_next = staged;
        else if (sync_rise_in)
            code_next = staged;
    end

    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
            code_reg <= `DDC_CODE_ZERO;
        else
            code_reg <= code_next;
    end

    assign code_out     = nzero_in ? code_reg : `DDC_CODE_ZERO;
    assign drive_en_out = power_in;

endmodule

/* rtl/ddc_dual_dac_ctrl.v */
`timescale 1ns/1ps
`include "ddc_consts.vh"

module ddc_dual_dac_ctrl
#(
    parameter CODE_W = 12
)
(
    input  wire              core_clk_in,
    input  wire              resetn_in,
    input  wire [7:0]        sfr_addr_in,
    input  wire              sfr_wr_in,
    input  wire [7:0]        sfr_wdata_in,
    input  wire              sfr_rd_in,
    output wire [7:0]        sfr_rdata_out,
    output wire              sfr_hit_out,
    output wire [CODE_W-1:0] ch0_code_out,
    output wire [CODE_W-1:0] ch1_code_out,
    output wire              ch0_span_supply_out,
    output wire              ch1_span_supply_out,
    output wire              ch0_drive_en_out,
    output wire              ch1_drive_en_out,
    output wire              mode8_out
);

    // register file state and next values
    reg  [7:0] ctrl_reg;
    reg  [7:0] ctrl_next;
    reg  [7:0] ch0_low_reg;
    reg  [7:0] ch0_low_next;
    reg  [7:0] ch0_high_reg;
    reg  [7:0] ch0_high_next;
    reg  [7:0] ch1_low_reg;
    reg  [7:0] ch1_low_next;
    reg  [7:0] ch1_high_reg;
    reg  [7:0] ch1_high_next;
    reg  [7:0] rdata_reg;
    reg  [7:0] rdata_next;

    // address decode and write strobes
    wire       sel_ctrl;
    wire       sel_ch0_low;
    wire       sel_ch0_high;
    wire       sel_ch1_low;
    wire       sel_ch1_high;
    wire       wr_ctrl;
    wire       wr_ch0_low;
    wire       wr_ch0_high;
    wire       wr_ch1_low;
    wire       wr_ch1_high;

    // control fields
    wire       mode8;
    wire       span_sel1;
    wire       span_sel0;
    wire       nzero1;
    wire       nzero0;
    wire       sync_on;
    wire       sync_req;
    wire       sync_rise;
    wire       power1;
    wire       power0;

    // data handed to the channels
    wire [7:0] ch0_low_stage;
    wire [7:0] ch0_high_stage;
    wire [7:0] ch1_low_stage;
    wire [7:0] ch1_high_stage;

    // one select per mapped address
    assign sel_ctrl     = (sfr_addr_in == `DDC_ADDR_CONTROL);
    assign sel_ch0_low  = (sfr_addr_in == `DDC_ADDR_CH0_LOW);
    assign sel_ch0_high = (sfr_addr_in == `DDC_ADDR_CH0_HIGH);
    assign sel_ch1_low  = (sfr_addr_in == `DDC_ADDR_CH1_LOW);
    assign sel_ch1_high = (sfr_addr_in == `DDC_ADDR_CH1_HIGH);

    // write strobes
    assign wr_ctrl      = sfr_wr_in && sel_ctrl;
    assign wr_ch0_low   = sfr_wr_in && sel_ch0_low;
    assign wr_ch0_high  = sfr_wr_in && sel_ch0_high;
    assign wr_ch1_low   = sfr_wr_in && sel_ch1_low;
    assign wr_ch1_high  = sfr_wr_in && sel_ch1_high;

    // any mapped address
    assign sfr_hit_out = (sfr_addr_in >= `DDC_ADDR_CH0_LOW) &&
                         (sfr_addr_in <= `DDC_ADDR_CONTROL);

    assign mode8     = ctrl_reg[`DDC_BIT_MODE8];
    assign span_sel1 = ctrl_reg[`DDC_BIT_SPAN1];
    assign span_sel0 = ctrl_reg[`DDC_BIT_SPAN0];
    assign nzero1    = ctrl_reg[`DDC_BIT_NZERO1];
    assign nzero0    = ctrl_reg[`DDC_BIT_NZERO0];
    assign sync_on   = ctrl_reg[`DDC_BIT_SYNC];
    assign power1    = ctrl_reg[`DDC_BIT_PWR1];
    assign power0    = ctrl_reg[`DDC_BIT_PWR0];

    // 0 to 1 edge of the sync bit caused by a control write
    assign sync_req  = sfr_wdata_in[`DDC_BIT_SYNC];
    assign sync_rise = wr_ctrl && !sync_on && sync_req;

    // control register
    always @*
    begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl)
        begin
            ctrl_next = sfr_wdata_in;
        end
    end

    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            ctrl_reg <= `DDC_RST_CONTROL;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // channel 0 low data register
    always @*
    begin
        ch0_low_next = ch0_low_reg;
        if (wr_ch0_low)
        begin
            ch0_low_next = sfr_wdata_in;
        end
    end

    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            ch0_low_reg <= `DDC_RST_DATA;
        end
        else
        begin
            ch0_low_reg <= ch0_low_next;
        end
    end

    // channel 0 high data register
    always @*
    begin
        ch0_high_next = ch0_high_reg;
        if (wr_ch0_high)
        begin
            ch0_high_next = sfr_wdata_in;
        end
    end

    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            ch0_high_reg <= `DDC_RST_DATA;
        end
        else
        begin
            ch0_high_reg <= ch0_high_next;
        end
    end

    // channel 1 low data register
    always @*
    begin
        ch1_low_next = ch1_low_reg;
        if (wr_ch1_low)
        begin
            ch1_low_next = sfr_wdata_in;
        end
    end

    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            ch1_low_reg <= `DDC_RST_DATA;
        end
        else
        begin
            ch1_low_reg <= ch1_low_next;
        end
    end

    // channel 1 high data register
    always @*
    begin
        ch1_high_next = ch1_high_reg;
        if (wr_ch1_high)
        begin
            ch1_high_next = sfr_wdata_in;
        end
    end

    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            ch1_high_reg <= `DDC_RST_DATA;
        end
        else
        begin
            ch1_high_reg <= ch1_high_next;
        end
    end

    // read data, mapped addresses return the register contents, unmapped addresses return zero
    always @*
    begin
        rdata_next = rdata_reg;
        if (sfr_rd_in)
        begin
            case (sfr_addr_in)
                `DDC_ADDR_CH0_LOW:  rdata_next = ch0_low_reg;
                `DDC_ADDR_CH0_HIGH: rdata_next = ch0_high_reg;
                `DDC_ADDR_CH1_LOW:  rdata_next = ch1_low_reg;
                `DDC_ADDR_CH1_HIGH: rdata_next = ch1_high_reg;
                `DDC_ADDR_CONTROL:  rdata_next = ctrl_reg;
                default:            rdata_next = `DDC_RST_DATA;
            endcase
        end
    end

    // read data holds until the next read
    always @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            rdata_reg <= `DDC_RST_DATA;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // data staged from the next register values so a low write while sync
    // is set loads the byte being written; high written before low is assumed
    assign ch0_low_stage  = ch0_low_next;
    assign ch0_high_stage = ch0_high_next;
    assign ch1_low_stage  = ch1_low_next;
    assign ch1_high_stage = ch1_high_next;

    // read data output and control fields steering the analog side
    assign sfr_rdata_out       = rdata_reg;
    assign mode8_out           = mode8;
    assign ch1_span_supply_out = span_sel1;
    assign ch0_span_supply_out = span_sel0;

    ddc_channel #(
        .CODE_W       (CODE_W)
    ) u_ch0 (
        .core_clk_in  (core_clk_in),
        .resetn_in    (resetn_in),
        .mode8_in     (mode8),
        .sync_in      (sync_on),
        .sync_rise_in (sync_rise),
        .low_wr_in    (wr_ch0_low),
        .low_val_in   (ch0_low_stage),
        .high_val_in  (ch0_high_stage),
        .nzero_in     (nzero0),
        .power_in     (power0),
        .code_out     (ch0_code_out),
        .drive_en_out (ch0_drive_en_out)
    );

    ddc_channel #(
        .CODE_W       (CODE_W)
    ) u_ch1 (
        .core_clk_in  (core_clk_in),
        .resetn_in    (resetn_in),
        .mode8_in     (mode8),
        .sync_in      (sync_on),
        .sync_rise_in (sync_rise),
        .low_wr_in    (wr_ch1_low),
        .low_val_in   (ch1_low_stage),
        .high_val_in  (ch1_high_stage),
        .nzero_in     (nzero1),
        .power_in     (power1),
        .code_out     (ch1_code_out),
        .drive_en_out (ch1_drive_en_out)
    );

endmodule
